// ==== tb_top.sv ====
// self-checking bench for the usb control and status block
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, exp, got) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) \
      begin \
         err_count++; \
         $display("MISMATCH %s expected %h seen %h", nm, exp, got); \
      end \
   end

module tb_top;
   localparam int SOF_N = 20;
   logic        mclk_i, rst_b_i, wr_i, rd_i;
   logic [7:0]  addr_i;
   logic [31:0] wdata_i, rdata_o;
   logic        j, se0, done, tx, odd, setup, tip;
   logic [7:0]  flags;
   logic [3:0]  ep;
   logic        irq, hold, brst, resm, eop, ppc, on, frm, hrst, lsp, ovr;
   logic [6:0]  dadr;
   int          err_count = 0, n_tests = 0, seed = 32'hdd5aec0b;
   int          frm_cnt = 0, eop_cnt = 0, rst_cnt = 0, ovr_cnt = 0;
   int          i, e, f, o, m_tog = 0;
   logic [31:0] r;
   logic [7:0]  m_een = 0, m_adr = 0, m_ien = 0, m_flg = 0, q[$];
   logic [5:0]  m_ctl = 0;
   logic        m_j = 1, m_se0 = 0, m_tip = 0;

   uoc_ctrl_status #(.SOF_CYCLES(SOF_N)) uoc_ctrl_status_inst (
      .mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .live_j_line_i(j), .live_se0_i(se0),
      .err_flags_i(flags), .xfer_done_i(done), .xfer_ep_i(ep), .xfer_tx_i(tx),
      .xfer_odd_i(odd), .setup_rx_i(setup), .token_in_progress_i(tip),
      .module_irq_flag_o(irq), .packet_hold_o(hold), .bus_reset_drive_o(brst),
      .resume_drive_o(resm), .ls_eop_o(eop), .pingpong_ptr_clear_o(ppc),
      .module_on_o(on), .frame_marker_o(frm), .host_logic_rst_o(hrst),
      .device_addr_o(dadr), .next_token_low_speed_o(lsp), .fifo_overrun_o(ovr));

   uoc_far_model uoc_far_model_inst (
      .mclk_i(mclk_i), .live_j_line_o(j), .live_se0_o(se0), .err_flags_o(flags),
      .xfer_done_o(done), .xfer_ep_o(ep), .xfer_tx_o(tx), .xfer_odd_o(odd),
      .setup_rx_o(setup), .token_in_progress_o(tip));

   // =====================================================================
   // clock, event counters, watchdog
   initial
   begin
      mclk_i = 1'b0;
      forever #4 mclk_i = ~mclk_i;
   end

   always @(posedge mclk_i)
   begin
      if (frm === 1'b1) frm_cnt++;
      if (eop === 1'b1) eop_cnt++;
      if (hrst === 1'b1) rst_cnt++;
      if (ovr === 1'b1) ovr_cnt++;
   end

   initial
   begin
      repeat (20000) @(posedge mclk_i);
      err_count++;
      complete_run();
   end

   // =====================================================================
   // bus tasks and reference model
   task automatic complete_run();
      if (err_count == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic settle();
      repeat (2) @(posedge mclk_i);
      #1;
   endtask

   task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
      r = $random(seed);
      @(posedge mclk_i);
      addr_i  <= a;
      wdata_i <= {r[31:8], d};
      wr_i    <= 1'b1;
      @(posedge mclk_i);
      wr_i    <= 1'b0;
      case (a)
         uoc_pkg::ERR_EN_OFS:   m_een = d;
         uoc_pkg::DEV_ADDR_OFS: m_adr = d;
         uoc_pkg::IRQ_EN_OFS:   m_ien = d;
         uoc_pkg::IRQ_FLAG_OFS: if (d[3] && q.size() != 0) void'(q.pop_front());
         uoc_pkg::CONTROL_OFS:
         begin
            if (d[3] != m_ctl[3]) m_tog++;
            m_ctl = m_ctl[3] ? {m_ctl[5], d[4:0]} : d[5:0];
         end
         default: ;
      endcase
   endtask

   function automatic logic [31:0] exp_rd(input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         uoc_pkg::ERR_EN_OFS:   v = m_een;
         uoc_pkg::STATUS_OFS:   if (q.size() != 0) v = q[0];
         uoc_pkg::CONTROL_OFS:  v = {m_j, m_se0, m_ctl[3] ? m_tip : m_ctl[5], m_ctl[4:0]};
         uoc_pkg::DEV_ADDR_OFS: v = m_adr;
         uoc_pkg::IRQ_FLAG_OFS: v = {4'h0, q.size() != 0, 1'b0, (m_flg & m_een) != 0, 1'b0};
         uoc_pkg::IRQ_EN_OFS:   v = m_ien;
         default: ;
      endcase
      return {24'h000000, v};
   endfunction

   task automatic bus_rd(input logic [7:0] a, input string nm);
      logic [31:0] x;
      x = exp_rd(a);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge mclk_i);
      rd_i   <= 1'b0;
      #1;
      `CHK(nm, x, rdata_o)
   endtask

   task automatic far(input logic jj, input logic ss, input logic [7:0] ff, input logic bb);
      m_j = jj;
      m_se0 = ss;
      m_flg = ff;
      m_tip = bb;
      uoc_far_model_inst.drive(jj, ss, ff, bb);
      repeat (2) @(posedge mclk_i);
   endtask

   task automatic chk_outs();
      settle();
      `CHK("irq", ((m_flg & m_een) != 0 && m_ien[1]) || (q.size() != 0 && m_ien[3]), irq)
      `CHK("hold", m_ctl[5] && !m_ctl[3], hold)
      `CHK("brst", m_ctl[4] && m_ctl[3], brst)
      `CHK("resume", m_ctl[2], resm)
      `CHK("ppclr", m_ctl[1], ppc)
      `CHK("on", m_ctl[0] && !m_ctl[3], on)
      `CHK("addr", m_adr[6:0], dadr)
      `CHK("lspd", m_adr[7], lsp)
   endtask

   // =====================================================================
   // main sequence
   initial
   begin
      rst_b_i = 1'b0;
      addr_i  = 8'h00;
      wdata_i = 32'h0000_0000;
      wr_i    = 1'b0;
      rd_i    = 1'b0;
      repeat (16) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      chk_outs();
      for (i = 0; i < 7; i++) bus_rd(8'(4 * i), "reset_reg");
      // single sources and their complements
      bus_wr(uoc_pkg::IRQ_EN_OFS, 8'h02);
      for (i = 0; i < 8; i++)
      begin
         bus_wr(uoc_pkg::ERR_EN_OFS, 8'(1 << i));
         far(1'b1, 1'b0, 8'(1 << i), 1'b0);
         chk_outs();
         far(1'b1, 1'b0, ~8'(1 << i), 1'b0);
         chk_outs();
      end
      // lone crc flag with its enable off
      bus_wr(uoc_pkg::ERR_EN_OFS, 8'hfb);
      far(1'b1, 1'b0, 8'h04, 1'b0);
      chk_outs();
      for (i = 0; i < 16; i++)
      begin
         r = $random(seed);
         bus_wr(uoc_pkg::IRQ_EN_OFS, {6'h00, r[16], 1'b0});
         bus_wr(uoc_pkg::ERR_EN_OFS, r[7:0]);
         far(1'b1, 1'b0, r[15:8], 1'b0);
         chk_outs();
         bus_rd(uoc_pkg::ERR_EN_OFS, "err_en");
      end
      for (i = 0; i < 4; i++)
      begin
         far(i[1], i[0], 8'h00, 1'b0);
         bus_rd(uoc_pkg::CONTROL_OFS, "line");
      end
      // five records into a four deep fifo
      bus_wr(uoc_pkg::IRQ_EN_OFS, 8'h08);
      o = ovr_cnt;
      for (i = 0; i < 5; i++)
      begin
         r = $random(seed);
         uoc_far_model_inst.push(r[3:0], r[4], r[5]);
         if (q.size() < uoc_pkg::FIFO_DEPTH) q.push_back({r[3:0], r[4], r[5], 2'b00});
      end
      uoc_far_model_inst.idle();
      chk_outs();
      `CHK("overrun", o + 1, ovr_cnt)
      // push and pop on one edge while full
      fork
         bus_wr(uoc_pkg::IRQ_FLAG_OFS, 8'h08);
         begin
            uoc_far_model_inst.push(4'h5, 1'b1, 1'b0);
            uoc_far_model_inst.idle();
         end
      join
      q.push_back(8'h58);
      settle();
      `CHK("overrun_pop", o + 1, ovr_cnt)
      for (i = 0; i < 5; i++)
      begin
         bus_rd(uoc_pkg::IRQ_FLAG_OFS, "tok_done");
         bus_rd(uoc_pkg::STATUS_OFS, "status");
         bus_wr(uoc_pkg::IRQ_FLAG_OFS, 8'h08);
      end
      chk_outs();
      // device mode control
      e = eop_cnt;
      bus_wr(uoc_pkg::CONTROL_OFS, 8'h23);
      chk_outs();
      bus_wr(uoc_pkg::CONTROL_OFS, 8'h04);
      bus_wr(uoc_pkg::CONTROL_OFS, 8'h00);
      uoc_far_model_inst.setup_pulse();
      m_ctl[5] = 1'b1;
      chk_outs();
      bus_rd(uoc_pkg::CONTROL_OFS, "setup_hold");
      bus_wr(uoc_pkg::CONTROL_OFS, 8'h00);
      // host mode control
      bus_wr(uoc_pkg::CONTROL_OFS, 8'h08);
      far(1'b1, 1'b0, 8'h00, 1'b1);
      bus_rd(uoc_pkg::CONTROL_OFS, "tok_busy");
      far(1'b1, 1'b0, 8'h00, 1'b0);
      bus_rd(uoc_pkg::CONTROL_OFS, "tok_idle");
      uoc_far_model_inst.setup_pulse();
      bus_wr(uoc_pkg::CONTROL_OFS, 8'h38);
      chk_outs();
      bus_wr(uoc_pkg::CONTROL_OFS, 8'h09);
      chk_outs();
      f = frm_cnt;
      repeat (100) @(posedge mclk_i);
      #1;
      `CHK("sof", f + 100 / SOF_N, frm_cnt)
      bus_wr(uoc_pkg::CONTROL_OFS, 8'h0c);
      chk_outs();
      repeat (50) @(posedge mclk_i);
      bus_wr(uoc_pkg::CONTROL_OFS, 8'h08);
      repeat (200) @(posedge mclk_i);
      #1;
      `CHK("ls_eop", e + uoc_pkg::LS_EOP_CYCLES, eop_cnt)
      bus_wr(uoc_pkg::CONTROL_OFS, 8'h00);
      // address register and an unmapped place
      for (i = 0; i < 4; i++)
      begin
         r = $random(seed);
         bus_wr(uoc_pkg::DEV_ADDR_OFS, r[7:0]);
         chk_outs();
         bus_rd(uoc_pkg::DEV_ADDR_OFS, "dev_addr");
      end
      bus_wr(8'h1c, 8'hff);
      bus_rd(8'h1c, "unmapped");
      settle();
      `CHK("host_rst", m_tog, rst_cnt)
      complete_run();
   end
endmodule // tb_top
`default_nettype wire

// ==== uoc_ctrl_status.sv ====
// usb control, status fifo and error interrupt gating block
// Operation
// - enable bits 7,6,5 gate bitstuff, matrix address and dma errors to interrupt.
// - enable bits 4,3,2 gate turnaround, field size and data crc errors.
// - enable bit 1 gates token crc error (device) or frame end error (host).
// - enable bit 0 gates the pid check error flag.
// - enabled errors reach the module interrupt only with global error enable set.
// - status bits 7-4 give endpoint number of last completed transfer.
// - status bit 3 is one for transmit, zero for receive.
// - status bit 2 is one for odd bank, zero for even bank.
// - status shows head of four entry fifo, valid while token done flag set.
// - clearing the token done flag pops one fifo entry.
// - control bit 7 reads live j line state.
// - control bit 6 reads live single ended zero.
// - device mode bit 5 holds packet processing, set by setup, cleared by software.
// - host mode bit 5 reads one while a token is executing.
// - host mode bit 4 drives usb bus reset while set.
// - bit 3 enables host role, every change resets host logic.
// - resume bit drives resume; host clear appends low speed end of packet.
// - bit 1 forces every ping-pong pointer to even bank.
// - device mode bit 0 enables module and supporting circuitry.
// - host mode bit 0 sends a start of frame token every 1 ms.
// - address bit 7 selects low speed next token, bits 6-0 hold address.
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module uoc_ctrl_status #(
   parameter int SOF_CYCLES = uoc_pkg::SOF_CYCLES
) (
   input  wire logic        mclk_i,
   input  wire logic        rst_b_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rdata_o,
   input  wire logic        live_j_line_i,
   input  wire logic        live_se0_i,
   input  wire logic [7:0]  err_flags_i,
   input  wire logic        xfer_done_i,
   input  wire logic [3:0]  xfer_ep_i,
   input  wire logic        xfer_tx_i,
   input  wire logic        xfer_odd_i,
   input  wire logic        setup_rx_i,
   input  wire logic        token_in_progress_i,
   output logic             module_irq_flag_o,
   output logic             packet_hold_o,
   output logic             bus_reset_drive_o,
   output logic             resume_drive_o,
   output logic             ls_eop_o,
   output logic             pingpong_ptr_clear_o,
   output logic             module_on_o,
   output logic             frame_marker_o,
   output logic             host_logic_rst_o,
   output logic [6:0]       device_addr_o,
   output logic             next_token_low_speed_o,
   output logic             fifo_overrun_o
);

   // =====================================================================
   // declarations
   logic [7:0]  err_en_q;
   logic [5:0]  ctl_q;
   logic [7:0]  addr_q;
   logic [7:0]  irq_en_q;
   logic [5:0]  fifo_mem_q [uoc_pkg::FIFO_DEPTH];
   logic [1:0]  wptr_q;
   logic [1:0]  rptr_q;
   logic [2:0]  count_q;
   logic        host_prev_q;
   logic        resume_prev_q;
   logic [16:0] sof_cnt_q;
   logic [7:0]  eop_cnt_q;
   uoc_pkg::uoc_rs_state_t rs_state_q;
   logic        host_mode;
   logic        host_toggle;
   logic        wr_err_en;
   logic        wr_ctl;
   logic        wr_addr;
   logic        wr_irq_en;
   logic        pop;
   logic        push;
   logic        token_done_flag;
   logic [5:0]  head;
   logic [7:0]  ctl_read;
   logic        err_hit;
   logic        resume_fall;
   logic [31:0] rdata_d;

   assign host_mode       = ctl_q[uoc_pkg::CTL_HOST_BIT];
   assign host_toggle     = host_mode != host_prev_q;
   assign wr_err_en       = wr_i && (addr_i == uoc_pkg::ERR_EN_OFS);
   assign wr_ctl          = wr_i && (addr_i == uoc_pkg::CONTROL_OFS);
   assign wr_addr         = wr_i && (addr_i == uoc_pkg::DEV_ADDR_OFS);
   assign wr_irq_en       = wr_i && (addr_i == uoc_pkg::IRQ_EN_OFS);
   assign token_done_flag = count_q != 3'h0;
   assign head            = fifo_mem_q[rptr_q];
   // write one to the token done flag pops the fifo
   assign pop  = wr_i && (addr_i == uoc_pkg::IRQ_FLAG_OFS)
                 && wdata_i[uoc_pkg::IRQ_TOK_BIT] && token_done_flag;
   assign push = xfer_done_i && ((count_q != 3'h4) || pop);
   // per source gating, bit 1 serves token crc or frame end by mode
   assign err_hit = |(err_flags_i & err_en_q);
   assign resume_fall = resume_prev_q && !ctl_q[uoc_pkg::CTL_RESUME_BIT];

   // =====================================================================
   // error enable and interrupt enable registers
   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         err_en_q <= uoc_pkg::ERR_EN_RST;
         irq_en_q <= uoc_pkg::IRQ_EN_RST;
      end
      else
      begin
         if (wr_err_en)
         begin
            err_en_q <= wdata_i[7:0];
         end
         if (wr_irq_en)
         begin
            irq_en_q <= wdata_i[7:0];
         end
      end
   end

   // =====================================================================
   // module interrupt flag
   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         module_irq_flag_o <= 1'b0;
      end
      else
      begin
         module_irq_flag_o <= (err_hit && irq_en_q[uoc_pkg::IRQ_ERR_BIT])
                              || (token_done_flag && irq_en_q[uoc_pkg::IRQ_TOK_BIT]);
      end
   end

   // =====================================================================
   // control register
   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         ctl_q <= uoc_pkg::CTL_RST;
      end
      else
      begin
         if (wr_ctl)
         begin
            ctl_q[4:0] <= wdata_i[4:0];
            if (!host_mode)
            begin
               ctl_q[uoc_pkg::CTL_HOLD_BIT] <= wdata_i[uoc_pkg::CTL_HOLD_BIT];
            end
         end
         // setup arrival wins over a software clear
         if (!host_mode && setup_rx_i)
         begin
            ctl_q[uoc_pkg::CTL_HOLD_BIT] <= 1'b1;
         end
      end
   end

   // =====================================================================
   // device address register
   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         addr_q <= uoc_pkg::ADDR_RST;
      end
      else if (wr_addr)
      begin
         addr_q <= wdata_i[7:0];
      end
   end

   // =====================================================================
   // transfer status fifo
   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         wptr_q  <= 2'h0;
         rptr_q  <= 2'h0;
         count_q <= 3'h0;
      end
      else
      begin
         if (push)
         begin
            fifo_mem_q[wptr_q] <= {xfer_ep_i, xfer_tx_i, xfer_odd_i};
            wptr_q             <= wptr_q + 2'h1;
         end
         if (pop)
         begin
            rptr_q <= rptr_q + 2'h1;
         end
         count_q <= count_q + {2'h0, push} - {2'h0, pop};
      end
   end

   // record lost when the fifo is full and not popped on the same edge
   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         fifo_overrun_o <= 1'b0;
      end
      else
      begin
         fifo_overrun_o <= xfer_done_i && !push;
      end
   end

   // =====================================================================
   // host role change detection and host logic reset
   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         host_prev_q      <= 1'b0;
         host_logic_rst_o <= 1'b0;
      end
      else
      begin
         host_prev_q      <= host_mode;
         host_logic_rst_o <= host_toggle;
      end
   end

   // =====================================================================
   // start of frame timer
   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         sof_cnt_q      <= 17'h0;
         frame_marker_o <= 1'b0;
      end
      else if (host_toggle || !host_mode || !ctl_q[uoc_pkg::CTL_ON_BIT])
      begin
         sof_cnt_q      <= 17'h0;
         frame_marker_o <= 1'b0;
      end
      else if (sof_cnt_q == 17'(SOF_CYCLES - 1))
      begin
         sof_cnt_q      <= 17'h0;
         frame_marker_o <= 1'b1;
      end
      else
      begin
         sof_cnt_q      <= sof_cnt_q + 17'h1;
         frame_marker_o <= 1'b0;
      end
   end

   // =====================================================================
   // resume signalling with low speed end of packet in host mode
   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         rs_state_q    <= uoc_pkg::UOC_RS_IDLE;
         resume_prev_q <= 1'b0;
         eop_cnt_q     <= 8'h0;
         ls_eop_o      <= 1'b0;
      end
      else
      begin
         resume_prev_q <= ctl_q[uoc_pkg::CTL_RESUME_BIT];
         case (rs_state_q)
            uoc_pkg::UOC_RS_IDLE:
            begin
               if (ctl_q[uoc_pkg::CTL_RESUME_BIT])
               begin
                  rs_state_q <= uoc_pkg::UOC_RS_RESUME;
               end
            end
            uoc_pkg::UOC_RS_RESUME:
            begin
               if (resume_fall && host_mode)
               begin
                  rs_state_q <= uoc_pkg::UOC_RS_EOP;
                  ls_eop_o   <= 1'b1;
                  eop_cnt_q  <= 8'(uoc_pkg::LS_EOP_CYCLES - 1);
               end
               else if (resume_fall)
               begin
                  rs_state_q <= uoc_pkg::UOC_RS_IDLE;
               end
            end
            uoc_pkg::UOC_RS_EOP:
            begin
               if (eop_cnt_q == 8'h0)
               begin
                  rs_state_q <= uoc_pkg::UOC_RS_IDLE;
                  ls_eop_o   <= 1'b0;
               end
               else
               begin
                  eop_cnt_q <= eop_cnt_q - 8'h1;
               end
            end
            default:
            begin
               rs_state_q <= uoc_pkg::UOC_RS_IDLE;
               ls_eop_o   <= 1'b0;
            end
         endcase
      end
   end

   // =====================================================================
   // line control outputs
   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         packet_hold_o          <= 1'b0;
         bus_reset_drive_o      <= 1'b0;
         resume_drive_o         <= 1'b0;
         pingpong_ptr_clear_o   <= 1'b0;
         module_on_o            <= 1'b0;
         device_addr_o          <= 7'h00;
         next_token_low_speed_o <= 1'b0;
      end
      else
      begin
         packet_hold_o          <= !host_mode && ctl_q[uoc_pkg::CTL_HOLD_BIT];
         bus_reset_drive_o      <= host_mode && ctl_q[uoc_pkg::CTL_BRST_BIT];
         resume_drive_o         <= ctl_q[uoc_pkg::CTL_RESUME_BIT];
         pingpong_ptr_clear_o   <= ctl_q[uoc_pkg::CTL_PPCLR_BIT];
         module_on_o            <= !host_mode && ctl_q[uoc_pkg::CTL_ON_BIT];
         device_addr_o          <= addr_q[6:0];
         next_token_low_speed_o <= addr_q[uoc_pkg::ADDR_LS_BIT];
      end
   end

   // =====================================================================
   // register read
   always_comb
   begin
      ctl_read = {live_j_line_i, live_se0_i,
                  host_mode ? token_in_progress_i : ctl_q[uoc_pkg::CTL_HOLD_BIT],
                  ctl_q[4:0]};
      rdata_d  = 32'h0;
      if (rd_i)
      begin
         case (addr_i)
            uoc_pkg::ERR_EN_OFS:   rdata_d = {24'h0, err_en_q};
            uoc_pkg::STATUS_OFS:   rdata_d = token_done_flag ? {24'h0, head, 2'h0} : 32'h0;
            uoc_pkg::CONTROL_OFS:  rdata_d = {24'h0, ctl_read};
            uoc_pkg::DEV_ADDR_OFS: rdata_d = {24'h0, addr_q};
            uoc_pkg::IRQ_FLAG_OFS: rdata_d = {28'h0, token_done_flag, 1'b0, err_hit, 1'b0};
            uoc_pkg::IRQ_EN_OFS:   rdata_d = {24'h0, irq_en_q};
            default:               rdata_d = 32'h0;
         endcase
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         rdata_o <= uoc_pkg::RDATA_RST;
      end
      else
      begin
         rdata_o <= rdata_d;
      end
   end

   // =====================================================================
   // assertions
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);

   property p_bitstuff_gate;
      err_flags_i == 8'h80 && err_en_q[7] && irq_en_q[uoc_pkg::IRQ_ERR_BIT] |=> module_irq_flag_o;
   endproperty
   a_bitstuff_gate: assert property (p_bitstuff_gate) else $error("bitstuff not gated");

   property p_crc_masked;
      err_flags_i == 8'h04 && !err_en_q[2] && !irq_en_q[uoc_pkg::IRQ_TOK_BIT]
      |=> !module_irq_flag_o;
   endproperty
   a_crc_masked: assert property (p_crc_masked) else $error("masked crc error raised irq");

   property p_global_gate;
      !irq_en_q[uoc_pkg::IRQ_ERR_BIT] && !irq_en_q[uoc_pkg::IRQ_TOK_BIT] |=> !module_irq_flag_o;
   endproperty
   a_global_gate: assert property (p_global_gate) else $error("irq without global enable");

   property p_status_record;
      xfer_done_i && count_q == 3'h0
      |=> head == {$past(xfer_ep_i), $past(xfer_tx_i), $past(xfer_odd_i)};
   endproperty
   a_status_record: assert property (p_status_record) else $error("status head wrong");

   property p_status_empty;
      rd_i && addr_i == uoc_pkg::STATUS_OFS && count_q == 3'h0 |=> rdata_o == 32'h0;
   endproperty
   a_status_empty: assert property (p_status_empty) else $error("status not zero");

   property p_pop_count;
      pop && !xfer_done_i |=> count_q == $past(count_q) - 3'h1;
   endproperty
   a_pop_count: assert property (p_pop_count) else $error("pop did not drop count");

   property p_setup_hold;
      !host_mode && setup_rx_i |=> ctl_q[uoc_pkg::CTL_HOLD_BIT] ##1 packet_hold_o;
   endproperty
   a_setup_hold: assert property (p_setup_hold) else $error("setup did not hold packets");

   property p_bus_reset;
      host_mode && ctl_q[uoc_pkg::CTL_BRST_BIT] |=> bus_reset_drive_o;
   endproperty
   a_bus_reset: assert property (p_bus_reset) else $error("bus reset not driven");

   property p_host_toggle;
      host_mode != $past(host_mode) |=> host_logic_rst_o;
   endproperty
   a_host_toggle: assert property (p_host_toggle) else $error("host toggle without reset");

   property p_ls_eop;
      rs_state_q == uoc_pkg::UOC_RS_RESUME && resume_fall && host_mode
      |=> ls_eop_o [*8];
   endproperty
   a_ls_eop: assert property (p_ls_eop) else $error("low speed eop missing");

   property p_sof_spacing;
      frame_marker_o |=> !frame_marker_o;
   endproperty
   a_sof_spacing: assert property (p_sof_spacing) else $error("frame marker too close");

   c_fifo_full:  cover property (count_q == 3'h4);
   c_overrun:    cover property (fifo_overrun_o);
   c_sof:        cover property (frame_marker_o);
   c_eop:        cover property (ls_eop_o ##1 !ls_eop_o);

endmodule // uoc_ctrl_status

`default_nettype wire

// ==== uoc_far_model.sv ====
// far-side link engine model: line state, error flags, transfer records
`timescale 1ns/100ps
`default_nettype none

module uoc_far_model (
   input  wire logic       mclk_i,
   output logic            live_j_line_o,
   output logic            live_se0_o,
   output logic [7:0]      err_flags_o,
   output logic            xfer_done_o,
   output logic [3:0]      xfer_ep_o,
   output logic            xfer_tx_o,
   output logic            xfer_odd_o,
   output logic            setup_rx_o,
   output logic            token_in_progress_o
);
   // =====================================================================
   // idle bus: j state, nothing pending
   initial
   begin
      live_j_line_o       = 1'b1;
      live_se0_o          = 1'b0;
      err_flags_o         = 8'h00;
      xfer_done_o         = 1'b0;
      xfer_ep_o           = 4'ha;
      xfer_tx_o           = 1'b0;
      xfer_odd_o          = 1'b1;
      setup_rx_o          = 1'b0;
      token_in_progress_o = 1'b0;
   end

   // =====================================================================
   // one completion record per call, back to back allowed
   task automatic push(input logic [3:0] ep, input logic tx, input logic odd);
      @(posedge mclk_i);
      xfer_done_o <= 1'b1;
      xfer_ep_o   <= ep;
      xfer_tx_o   <= tx;
      xfer_odd_o  <= odd;
   endtask

   // record fields scrambled once released
   task automatic idle();
      @(posedge mclk_i);
      xfer_done_o <= 1'b0;
      xfer_ep_o   <= ~xfer_ep_o;
      xfer_tx_o   <= ~xfer_tx_o;
      xfer_odd_o  <= ~xfer_odd_o;
   endtask

   task automatic setup_pulse();
      @(posedge mclk_i);
      setup_rx_o <= 1'b1;
      @(posedge mclk_i);
      setup_rx_o <= 1'b0;
   endtask

   task automatic drive(input logic j, input logic se0, input logic [7:0] f, input logic b);
      @(posedge mclk_i);
      live_j_line_o       <= j;
      live_se0_o          <= se0;
      err_flags_o         <= f;
      token_in_progress_o <= b;
   endtask
endmodule // uoc_far_model
`default_nettype wire

// ==== uoc_pkg.sv ====
// constants for the usb control and status register block
package uoc_pkg;

   // =====================================================================
   // register byte addresses
   localparam logic [7:0] ERR_EN_OFS    = 8'h00;
   localparam logic [7:0] STATUS_OFS    = 8'h04;
   localparam logic [7:0] CONTROL_OFS   = 8'h08;
   localparam logic [7:0] DEV_ADDR_OFS  = 8'h0c;
   localparam logic [7:0] IRQ_FLAG_OFS  = 8'h10;
   localparam logic [7:0] IRQ_EN_OFS    = 8'h14;

   // =====================================================================
   // field positions
   localparam int CTL_J_BIT       = 7;
   localparam int CTL_SE0_BIT     = 6;
   localparam int CTL_HOLD_BIT    = 5;
   localparam int CTL_BRST_BIT    = 4;
   localparam int CTL_HOST_BIT    = 3;
   localparam int CTL_RESUME_BIT  = 2;
   localparam int CTL_PPCLR_BIT   = 1;
   localparam int CTL_ON_BIT      = 0;
   localparam int IRQ_ERR_BIT     = 1;
   localparam int IRQ_TOK_BIT     = 3;
   localparam int STAT_EP_LSB     = 4;
   localparam int STAT_DIR_BIT    = 3;
   localparam int STAT_ODD_BIT    = 2;
   localparam int ADDR_LS_BIT     = 7;

   // =====================================================================
   // reset values
   localparam logic [7:0]  ERR_EN_RST  = 8'h00;
   localparam logic [5:0]  CTL_RST     = 6'h00;
   localparam logic [7:0]  ADDR_RST    = 8'h00;
   localparam logic [7:0]  IRQ_EN_RST  = 8'h00;
   localparam logic [31:0] RDATA_RST   = 32'h0000_0000;

   // =====================================================================
   // timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int SOF_PERIOD_NS = 1000000;
   localparam int SOF_CYCLES    = SOF_PERIOD_NS / CLK_PERIOD_NS;
   localparam int LS_EOP_NS     = 1334;
   localparam int LS_EOP_CYCLES = (LS_EOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // =====================================================================
   // status fifo
   localparam int FIFO_DEPTH = 4;

   // resume signalling states
   typedef enum logic [1:0] {
      UOC_RS_IDLE   = 2'b00,
      UOC_RS_RESUME = 2'b01,
      UOC_RS_EOP    = 2'b11
   } uoc_rs_state_t;

endpackage : uoc_pkg
